// >>> hdl/rtcfc_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RTCFC_CFG_SVH
`define RTCFC_CFG_SVH
// ************************************************************
// Register map
// ************************************************************
`define RTCFC_ADR_STATUS   4'h0
`define RTCFC_ADR_TIME     4'h4
`define RTCFC_ADR_COUNT    4'h8
// ************************************************************
// Status field positions
// ************************************************************
`define RTCFC_BIT_READ     0
`define RTCFC_BIT_WRITE    1
`define RTCFC_BIT_CAL      2
`define RTCFC_BIT_OSCILLATOR_FAIL_FLAG     4
`define RTCFC_BIT_PF       5
// ************************************************************
// Reset values and timing
// ************************************************************
`define RTCFC_RST_CTRL     1'h0
`define RTCFC_OSC_WAIT_MS  5
`define RTCFC_CLK_HZ       100000000
`define RTCFC_SQW_HZ       512
`endif

// >>> hdl/rtcfc_pkg.sv
// Types shared by the flag and update control block
package rtcfc_pkg;
  typedef enum logic [2:0] {
    RTCFC_WAIT = 3'b001,
    RTCFC_RUN  = 3'b010,
    RTCFC_DONE = 3'b100
  } rtcfc_osc_t;
endpackage : rtcfc_pkg

// >>> hdl/rtcfc_top.sv
// Real time clock flags, calibration output and update freeze control
// How it works
// - Power fail flag goes to one while supply is below threshold.
// - Power fail flag clears on status read and at reset.
// - Oscillator fail flag set if enabled oscillator silent in first 5 ms.
// - Oscillator fail flag is never self cleared; host writes zero to clear.
// - Calibration bit one puts 512 Hz square wave on interrupt pin.
// - Calibration bit resets to zero.
// - Write freeze stops time updates and allows host time writes.
// - Dropping write freeze after a change loads new base time.
// - Write freeze bit resets to zero.
`timescale 1ns/1ps
`include "rtcfc_cfg.svh"
module rtcfc_top
  import rtcfc_pkg::*;
#(
  parameter int OSC_WAIT_CYC = (`RTCFC_OSC_WAIT_MS * (`RTCFC_CLK_HZ / 1000)),
  parameter int SQW_HALF_CYC = `RTCFC_CLK_HZ / (2 * `RTCFC_SQW_HZ),
  parameter int TW           = 32
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [3:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Device pins
  input  wire logic          power_low_i,
  input  wire logic          osc_enable_i,
  input  wire logic          osc_running_i,
  input  wire logic          tick_i,
  input  wire logic          alarm_irq_i,
  output logic               irq_o,
  output logic               osc_fail_flag_o
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] pl_s;
  logic [2:0] or_s;
  logic       power_low;
  logic       osc_run;
  // Three stages, change accepted when last two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pl_s <= 3'h0;
      or_s <= 3'h0;
    end else begin
      pl_s <= {pl_s[1:0], power_low_i};
      or_s <= {or_s[1:0], osc_running_i};
    end
  end
  // Filtered levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_low <= 1'b0;
      osc_run   <= 1'b0;
    end else begin
      if (pl_s[1] == pl_s[2]) power_low <= pl_s[2];
      if (or_s[1] == or_s[2]) osc_run <= or_s[2];
    end
  end
  // ************************************************************
  // Bus decode
  // ************************************************************
  logic wr_stb;
  logic rd_stb;
  logic st_hit;
  logic next_ack;
  assign next_ack = cyc_i && stb_i && !ack_o;
  assign wr_stb   = next_ack && we_i;
  assign rd_stb   = next_ack && !we_i;
  assign st_hit   = (adr_i == `RTCFC_ADR_STATUS) && sel_i[0];
  // ************************************************************
  // Status and control bits
  // ************************************************************
  logic       pf_flag;
  logic       oscillator_fail_flag_flag;
  logic       cal_en;
  logic       wr_frz;
  logic       rd_frz;
  logic       time_dirty;
  logic       load_base;
  rtcfc_osc_t osc_st;
  logic [31:0] osc_cnt;
  // Power fail flag: set wins over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pf_flag <= `RTCFC_RST_CTRL;
    end else if (power_low) begin
      pf_flag <= 1'b1;
    end else if (rd_stb && st_hit) begin
      pf_flag <= 1'b0;
    end
  end
  // Oscillator start check during the first window after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_st  <= RTCFC_WAIT;
      osc_cnt <= 32'h0;
    end else begin
      unique case (osc_st)
        RTCFC_WAIT: begin
          osc_st <= RTCFC_RUN;
        end
        RTCFC_RUN: begin
          if (!osc_enable_i || osc_run) osc_st <= RTCFC_DONE;
          else if (osc_cnt == 32'(OSC_WAIT_CYC - 1)) osc_st <= RTCFC_DONE;
          else osc_cnt <= osc_cnt + 32'h1;
        end
        RTCFC_DONE: begin
          osc_st <= RTCFC_DONE;
        end
      endcase
    end
  end
  logic osc_timeout;
  // Window ran out with the oscillator still silent
  assign osc_timeout = (osc_st == RTCFC_RUN) && osc_enable_i && !osc_run
                       && (osc_cnt == 32'(OSC_WAIT_CYC - 1));
  // Oscillator fail flag: only reset or a host write of zero clears it, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oscillator_fail_flag_flag <= 1'b0;
    end else if (osc_timeout) begin
      oscillator_fail_flag_flag <= 1'b1;
    end else if (wr_stb && st_hit && !dat_i[`RTCFC_BIT_OSCILLATOR_FAIL_FLAG]) begin
      oscillator_fail_flag_flag <= 1'b0;
    end
  end
  // Control bits written by the host
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_en <= `RTCFC_RST_CTRL;
      wr_frz <= `RTCFC_RST_CTRL;
      rd_frz <= `RTCFC_RST_CTRL;
    end else if (wr_stb && st_hit) begin
      cal_en <= dat_i[`RTCFC_BIT_CAL];
      wr_frz <= dat_i[`RTCFC_BIT_WRITE];
      rd_frz <= dat_i[`RTCFC_BIT_READ];
    end
  end
  // ************************************************************
  // Timekeeping registers and counter
  // ************************************************************
  logic [TW-1:0] time_reg;
  logic [TW-1:0] counter;
  logic          time_wr;
  // Time writes only while frozen; base load on unfreeze after a change
  assign time_wr   = wr_stb && (adr_i == `RTCFC_ADR_TIME) && wr_frz;
  assign load_base = wr_stb && st_hit && wr_frz && !dat_i[`RTCFC_BIT_WRITE] && time_dirty;
  // Change tracking while frozen
  always_ff @(posedge clk_i) begin
    if (rst_i) time_dirty <= 1'b0;
    else if (time_wr) time_dirty <= 1'b1;
    else if (load_base) time_dirty <= 1'b0;
  end
  // Running counter, reloaded from the registers as new base
  always_ff @(posedge clk_i) begin
    if (rst_i) counter <= '0;
    else if (load_base) counter <= time_reg;
    else if (tick_i) counter <= counter + 1'b1;
  end
  // Holding registers follow the counter unless frozen
  always_ff @(posedge clk_i) begin
    if (rst_i) time_reg <= '0;
    else if (time_wr) time_reg <= dat_i[TW-1:0];
    else if (!wr_frz && !rd_frz) time_reg <= counter;
  end
  // ************************************************************
  // Calibration square wave
  // ************************************************************
  logic [31:0] sqw_cnt;
  logic        sqw;
  // Toggle every half period while calibration is on
  always_ff @(posedge clk_i) begin
    if (rst_i || !cal_en) begin
      sqw_cnt <= 32'h0;
      sqw     <= 1'b0;
    end else if (sqw_cnt == 32'(SQW_HALF_CYC - 1)) begin
      sqw_cnt <= 32'h0;
      sqw     <= ~sqw;
    end else begin
      sqw_cnt <= sqw_cnt + 32'h1;
    end
  end
  // Interrupt pin mux and flag output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o           <= 1'b0;
      osc_fail_flag_o <= 1'b0;
    end else begin
      irq_o           <= cal_en ? sqw : alarm_irq_i;
      osc_fail_flag_o <= oscillator_fail_flag_flag;
    end
  end
  // ************************************************************
  // Bus answer
  // ************************************************************
  // One-cycle acknowledge with registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= next_ack;
      if (rd_stb) begin
        unique case (adr_i)
          `RTCFC_ADR_STATUS: dat_o <= {26'h0, pf_flag, oscillator_fail_flag_flag, 1'b0, cal_en, wr_frz, rd_frz};
          `RTCFC_ADR_TIME:   dat_o <= 32'(time_reg);
          `RTCFC_ADR_COUNT:  dat_o <= 32'(counter);
          default:           dat_o <= 32'h0;
        endcase
      end
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  a_pf_set: assert property (@(posedge clk_i) disable iff (rst_i)
    power_low |=> pf_flag) else $error("power fail flag not set");
  a_pf_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_stb && st_hit && !power_low) |=> !pf_flag) else $error("power fail flag not cleared");
  a_oscillator_fail_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_timeout |=> oscillator_fail_flag_flag) else $error("osc fail not flagged");
  a_oscillator_fail_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (oscillator_fail_flag_flag && !(wr_stb && st_hit)) |=> oscillator_fail_flag_flag) else $error("osc fail self cleared");
  a_sqw_half: assert property (@(posedge clk_i) disable iff (rst_i)
    (cal_en && $changed(sqw)) |-> $past(sqw_cnt) == 32'(SQW_HALF_CYC - 1)) else $error("bad half period");
  a_irq_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cal_en && !$past(cal_en)) |=> irq_o == $past(alarm_irq_i)) else $error("irq not passed");
  sequence s_frz_write;
    wr_stb && st_hit && wr_frz && !dat_i[`RTCFC_BIT_WRITE] && time_dirty;
  endsequence
  a_base_load: assert property (@(posedge clk_i) disable iff (rst_i)
    s_frz_write |=> counter == $past(time_reg)) else $error("base time not loaded");
  a_frz_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_frz && !time_wr) |=> $stable(time_reg)) else $error("frozen registers moved");
  a_rd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_frz && !time_wr) |=> $stable(time_reg)) else $error("read freeze moved");
  a_ctrl_rst: assert property (@(posedge clk_i)
    rst_i |=> (!cal_en && !wr_frz)) else $error("control not reset");
  // ************************************************************
  // Bus, status and timekeeping checks
  // ************************************************************
  // A taken request is answered on the next edge
  sequence s_req_taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req_taken |=> ack_o) else $error("request not acknowledged");
  // Acknowledge lasts one cycle
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held too long");
  // Acknowledge only follows a request
  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> ($past(cyc_i) && $past(stb_i))) else $error("ack without request");
  // Unmapped reads return zero
  a_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_stb && !(adr_i inside {`RTCFC_ADR_STATUS, `RTCFC_ADR_TIME, `RTCFC_ADR_COUNT})) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Read data stands until the next read
  a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_stb |=> $stable(dat_o)) else $error("read data moved");
  // Power fail flag cleared by reset
  a_pf_rst: assert property (@(posedge clk_i)
    rst_i |=> !pf_flag) else $error("power fail flag not reset");
  // Power fail flag only cleared by a status read
  a_pf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (pf_flag && !(rd_stb && st_hit)) |=> pf_flag) else $error("power fail flag lost");
  // Host write of zero clears the oscillator fail flag
  a_oscillator_fail_flag_wclr: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && st_hit && !dat_i[`RTCFC_BIT_OSCILLATOR_FAIL_FLAG] && !osc_timeout) |=> !oscillator_fail_flag_flag) else $error("osc fail not cleared");
  // Only the start check sets the oscillator fail flag
  a_oscillator_fail_flag_no_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (!oscillator_fail_flag_flag && !osc_timeout) |=> !oscillator_fail_flag_flag) else $error("osc fail set by write");
  // Start check window never overruns
  a_osc_window: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_cnt <= 32'(OSC_WAIT_CYC - 1)) else $error("osc window overrun");
  // Flag pin copies the flag
  a_oscillator_fail_flag_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> osc_fail_flag_o == $past(oscillator_fail_flag_flag)) else $error("osc fail pin wrong");
  // Status write with the calibration bit set enables calibration
  sequence s_cal_on;
    wr_stb && st_hit && dat_i[`RTCFC_BIT_CAL];
  endsequence
  a_cal_on: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cal_on |=> cal_en) else $error("calibration not enabled");
  // Status write with the write bit set freezes updates
  a_frz_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_stb && st_hit && dat_i[`RTCFC_BIT_WRITE]) |=> wr_frz) else $error("write freeze not set");
  // Control bits move only on a status write
  a_ctrl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_stb && st_hit) |=> ($stable(cal_en) && $stable(wr_frz) && $stable(rd_frz))) else $error("control moved");
  // Frozen time write lands in the holding register
  a_time_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    time_wr |=> time_reg == TW'($past(dat_i))) else $error("time write lost");
  // Holding register tracks the counter when free
  a_time_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wr_frz && !rd_frz && !time_wr) |=> time_reg == $past(counter)) else $error("holding not updated");
  // Counter only moves on a tick or a base load
  a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!load_base && !tick_i) |=> $stable(counter)) else $error("counter moved");
  // Square wave drives the pin while calibrating
  a_irq_sqw: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_en |=> irq_o == $past(sqw)) else $error("square wave not on pin");
  // Square wave parked while calibration is off
  a_sqw_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !cal_en |=> (!sqw && sqw_cnt == 32'h0)) else $error("square wave not parked");
endmodule : rtcfc_top

// >>> tb/rtcfc_host.sv
// Host side Wishbone classic master model
`timescale 1ns/1ps
module rtcfc_host (
  // Clock
  input  wire logic        clk_i,
  // Slave answer
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  // Request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [3:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  // Idle bus
  initial begin
    cyc_o = 0;
    stb_o = 0;
    we_o  = 0;
    adr_o = 4'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // One single cycle; request held until ack
  task xfer(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1;
    stb_o <= 1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 0;
    stb_o <= 0;
    we_o  <= 0;
    dat_o <= ~d; // Released data no longer shows last value
    @(posedge clk_i);
  endtask : xfer
endmodule : rtcfc_host

// >>> tb/test_rtc_flag_and_update_control.sv
// Self-checking bench for the flag and update control block
`timescale 1ns/1ps
module test_rtc_flag_and_update_control;
  import rtcfc_pkg::*;
  logic clk_i = 0, rst_i = 1, we, cyc, stb, ack, irq, oscillator_fail_flag;
  logic pwr = 0, tick = 0, alarm = 0, osc_en = 1, osc_run = 0, pv;
  logic [3:0] adr, sel;
  logic [31:0] wd, rdat, q, d, cnt;
  integer seed = 32'ha5d10313;
  int miscompares = 0, num_checks = 0, n;
  always #5 clk_i = ~clk_i;
  rtcfc_host host_u (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  rtcfc_top #(.OSC_WAIT_CYC(50), .SQW_HALF_CYC(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat),
    .ack_o(ack), .power_low_i(pwr), .osc_enable_i(osc_en), .osc_running_i(osc_run),
    .tick_i(tick), .alarm_irq_i(alarm), .irq_o(irq), .osc_fail_flag_o(oscillator_fail_flag));
  // Verdict and end of run
  task tally_and_finish;
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Compare seen against expected
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] v);
    host_u.xfer(1'b1, a, 4'hf, v, q);
  endtask : wr
  task rd(input logic [3:0] a);
    host_u.xfer(1'b0, a, 4'hf, 32'h0, q);
  endtask : rd
  // Count increment pulses
  task tk(input int k);
    repeat (k) begin
      @(posedge clk_i) tick <= 1;
      @(posedge clk_i) tick <= 0;
    end
  endtask : tk
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    rd(4'h0); check("status rst", q, 32'h0);
    repeat (60) @(posedge clk_i);
    check("oscillator_fail_flag pin", oscillator_fail_flag, 1);
    wr(4'h0, 32'h10); rd(4'h0); check("oscillator_fail_flag w1", q[4], 1);
    wr(4'h0, 32'h0); rd(4'h0); check("oscillator_fail_flag w0", q[4], 0);
    @(posedge clk_i) pwr <= 1;
    repeat (8) @(posedge clk_i);
    pwr <= 0;
    repeat (8) @(posedge clk_i);
    rd(4'h0); check("pf set", q[5], 1);
    rd(4'h0); check("pf rdclr", q[5], 0);
    wr(4'h0, 32'h4);
    n = 0;
    pv = irq;
    repeat (64) begin
      @(posedge clk_i);
      if (irq !== pv) n++;
      pv = irq;
    end
    check("sqw toggles", n, 64 / 8);
    wr(4'h0, 32'h0);
    @(posedge clk_i) alarm <= 1;
    repeat (3) @(posedge clk_i);
    check("irq alarm", irq, 1);
    @(posedge clk_i) alarm <= 0;
    repeat (3) @(posedge clk_i);
    check("irq idle", irq, 0);
    cnt = 32'h0;
    // Random base times through freeze, load and read freeze
    repeat (3) begin
      d = $random(seed);
      wr(4'h4, ~d); rd(4'h4); check("time locked", q, cnt);
      wr(4'h0, 32'h2); wr(4'h4, d); tk(3);
      rd(4'h4); check("time frozen", q, d);
      wr(4'h0, 32'h0); rd(4'h8); check("base load", q, d);
      tk(2); rd(4'h4); check("time runs", q, d + 2);
      wr(4'h0, 32'h1); tk(4);
      rd(4'h4); check("rfreeze", q, d + 2);
      rd(4'h8); check("count runs", q, d + 6);
      wr(4'h0, 32'h0); rd(4'h4); check("rfree", q, d + 6);
      cnt = d + 6;
    end
    // Unfreeze without a time change keeps the running count
    wr(4'h0, 32'h2);
    tk(2);
    wr(4'h0, 32'h0);
    rd(4'h8);
    check("no reload", q, cnt + 2);
    // Status write without its byte lane is ignored
    host_u.xfer(1'b1, 4'h0, 4'he, 32'h4, q);
    rd(4'h0);
    check("sel gate", q, 32'h0);
    // Mid-run resets with the oscillator disabled, then running
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, 32'h7);
      osc_en <= i[0];
      osc_run <= i[0];
      @(posedge clk_i) rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      rd(4'h0);
      check("status rst2", q, 32'h0);
      repeat (60) @(posedge clk_i);
      check("oscillator_fail_flag quiet", oscillator_fail_flag, 0);
    end
    rd(4'hc); check("unmapped", q, 32'h0);
    tally_and_finish;
  end
endmodule : test_rtc_flag_and_update_control
